// ### hw/sbg_pkg.sv
// Package of constants and types for the serial rate generator block
package sbg_pkg;

  // ****************************************
  // Register word offsets (byte addresses)
  // ****************************************
  localparam logic [11:0] ADDR_TX_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_RX_CTRL   = 12'h004;
  localparam logic [11:0] ADDR_RATE_CTRL = 12'h008;
  localparam logic [11:0] ADDR_DIV_HIGH  = 12'h00c;
  localparam logic [11:0] ADDR_DIV_LOW   = 12'h010;
  localparam logic [11:0] ADDR_RX_BUF    = 12'h014;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int TX_SYNC_BIT    = 4;
  localparam int TX_HSPEED_BIT  = 2;
  localparam int RX_ENABLE_BIT  = 7;
  localparam int RC_OVF_BIT     = 7;
  localparam int RC_IDLE_BIT    = 6;
  localparam int RC_WIDE_BIT    = 3;
  localparam int RC_WAKE_BIT    = 1;
  localparam int RC_ABD_BIT     = 0;

  // ****************************************
  // Reset values and writable masks
  // ****************************************
  localparam logic [7:0] TX_CTRL_RESET   = 8'h02;
  localparam logic [7:0] RX_CTRL_RESET   = 8'h00;
  localparam logic [7:0] RATE_CTRL_RESET = 8'h00;
  localparam logic [7:0] TX_CTRL_WMASK   = 8'hfd;
  localparam logic [7:0] RATE_CTRL_WMASK = 8'h9b;

  // ****************************************
  // Timing constants
  // ****************************************
  localparam logic [1:0] PRESCALE_LAST_SYNC = 2'h0; // divide by 4 total
  localparam logic [3:0] PRESCALE_LAST_HI   = 4'h3; // divide by 16 total
  localparam logic [5:0] PRESCALE_LAST_LO   = 6'h0f; // divide by 64 total
  localparam logic [5:0] PRESCALE_FULL_LO   = 6'h3f;
  localparam logic [5:0] PRESCALE_FULL_HI   = 6'h0f;
  localparam logic [5:0] PRESCALE_FULL_SYN  = 6'h03;
  localparam logic [2:0] ABD_DIV_LAST       = 3'h7; // one eighth
  localparam logic [2:0] ABD_EDGES          = 3'h5;
  localparam logic [1:0] SAMPLE_FIRST       = 2'h1;

  // ****************************************
  // Measurement states
  // ****************************************
  typedef enum logic [3:0] {
    SBG_IDLE  = 4'h1,
    SBG_START = 4'h2,
    SBG_FIRST = 4'h4,
    SBG_COUNT = 4'h8
  } sbg_state_type;

  typedef struct packed {
    logic [7:0] tx_ctrl;
    logic [7:0] rx_ctrl;
    logic [7:0] rate_ctrl;
    logic [15:0] divisor;
    logic [15:0] timer;
    logic [5:0] prescale;
    logic [2:0] abd_div;
    logic [2:0] edges;
    sbg_state_type state;
    logic [1:0] rx_sync;
    logic       rx_prev;
    logic [2:0] votes;
    logic       rx_vote;
    logic       rx_flag;
    logic       baud_tick;
    logic       tick16;
    logic [31:0] prdata;
    logic       pready;
    logic       hold;
  } sbg_state_all_type;

endpackage

// ### hw/sbg_rate_gen.sv
// Baud rate generator with majority sampling and automatic rate measurement
// Operation
// - Receive line sampled three times per prescaler period
// - Rate divides clock by 64(n+1), 16(n+1) or 4(n+1)
// - Measurement only asynchronous with wake disabled
// - Enabling measurement clears counter, awaits start bit
// - Receive line edges start and stop the counter during measurement
// - Measurement spans both low and high bits
// - Counting starts at first rising edge
// - Fifth rising edge leaves period in divisor
// - Hardware clears enable at fifth rising edge
// - Rollover sets overflow flag, software writable
// - Rollover does not end the measurement
// - Counter increments at one eighth selected rate
// - Divisor bytes form one 16-bit counter
// - Receiver held idle during measurement
// - Receive flag raised at fifth rising edge
// - Reading receive buffer clears receive flag
// - With wake enabled, measure byte after break
// - Default 8-bit divisor, 16-bit when selected
// - Divisor reloads free-running timer making ticks
// - Divisor write resets timer immediately
//
// Decided for this implementation: the placing of the registers and the APB slave port.
module sbg_rate_gen (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        rx_pin_i,
  input  wire logic        wake_break_seen_i,
  output logic             baud_tick_o,
  output logic             sample_tick_o,
  output logic             rx_level_o,
  output logic             rx_hold_idle_o,
  output logic             receive_flag_o
);

  // ****************************************
  // State
  // ****************************************
  // All state in one struct keeps reset and registering in one place
  sbg_pkg::sbg_state_all_type cur_reg;
  sbg_pkg::sbg_state_all_type cur_next;

  // ****************************************
  // Helper functions
  // ****************************************

  // Last prescaler count for the active mode
  function automatic logic [5:0] prescale_last(input logic [7:0] tx,
                                               input logic [7:0] rc);
    logic sync_m;
    logic fast;
    sync_m = tx[sbg_pkg::TX_SYNC_BIT];
    fast = tx[sbg_pkg::TX_HSPEED_BIT] ^ rc[sbg_pkg::RC_WIDE_BIT];
    if (sync_m ||
        (tx[sbg_pkg::TX_HSPEED_BIT] && rc[sbg_pkg::RC_WIDE_BIT])) begin
      prescale_last = sbg_pkg::PRESCALE_FULL_SYN;
    end else if (fast) begin
      prescale_last = sbg_pkg::PRESCALE_FULL_HI;
    end else begin
      prescale_last = sbg_pkg::PRESCALE_FULL_LO;
    end
  endfunction

  // Reload value of the timer, low byte only in narrow mode
  function automatic logic [15:0] reload(input logic [15:0] div,
                                         input logic [7:0] rc);
    if (rc[sbg_pkg::RC_WIDE_BIT]) begin
      reload = div;
    end else begin
      reload = {8'h00, div[7:0]};
    end
  endfunction

  // ****************************************
  // Decoded strobes
  // ****************************************
  // Filled at the top of the comb process, read only within it
  logic        access;
  logic        wr;
  logic        rd;
  logic        measuring;
  logic        abd_allowed;
  logic        rx_rise;
  logic        rx_fall;
  logic        clk_tick;
  logic        abd_tick;
  logic        div_write;
  logic [5:0]  ps_last;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    cur_next = cur_reg;
    access = psel_i && penable_i && !cur_reg.pready;
    wr = access && pwrite_i;
    rd = access && !pwrite_i;
    ps_last = prescale_last(cur_reg.tx_ctrl, cur_reg.rate_ctrl);
    measuring = cur_reg.state != sbg_pkg::SBG_IDLE;
    abd_allowed = !cur_reg.tx_ctrl[sbg_pkg::TX_SYNC_BIT] &&
                  !cur_reg.rate_ctrl[sbg_pkg::RC_WAKE_BIT];
    rx_rise = cur_reg.rx_sync[1] && !cur_reg.rx_prev;
    rx_fall = !cur_reg.rx_sync[1] && cur_reg.rx_prev;
    clk_tick = cur_reg.prescale == ps_last;
    abd_tick = clk_tick && (cur_reg.abd_div == sbg_pkg::ABD_DIV_LAST);
    div_write = wr && (paddr_i == sbg_pkg::ADDR_DIV_HIGH ||
                       paddr_i == sbg_pkg::ADDR_DIV_LOW);

    // ****************************************
    // Receive line sampling
    // ****************************************
    // Two-flop synchroniser; only the second flop feeds logic
    cur_next.rx_sync = {cur_reg.rx_sync[0], rx_pin_i};
    cur_next.rx_prev = cur_reg.rx_sync[1];
    cur_next.baud_tick = 1'b0;
    cur_next.tick16 = 1'b0;

    // ****************************************
    // Rate timer
    // ****************************************
    // Prescaler restarts on divisor write too, so the next period is whole
    // Prescaler runs free; divides clock down to the selected rate
    if (clk_tick || div_write) begin
      cur_next.prescale = 6'h00;
    end else begin
      cur_next.prescale = cur_reg.prescale + 6'h01;
    end

    // Free-running timer reloaded from the divisor
    if (div_write) begin
      cur_next.timer = 16'h0000;
    end else if (!measuring && clk_tick) begin
      if (cur_reg.timer >= reload(cur_reg.divisor, cur_reg.rate_ctrl)) begin
        cur_next.timer = 16'h0000;
        cur_next.baud_tick = 1'b1;
      end else begin
        cur_next.timer = cur_reg.timer + 16'h0001;
      end
    end

    // Sample tick: once per bit, with the baud tick, when the timer reaches its reload value
    if (!measuring && clk_tick &&
        cur_reg.timer == reload(cur_reg.divisor, cur_reg.rate_ctrl)) begin
      cur_next.tick16 = 1'b1;
    end

    // Limitation: sample slots follow the prescaler phase, not the start
    // edge, so very short pulses are voted away rather than re-centred
    // Majority vote of three consecutive samples near the start of each prescaler period longer than four clocks
    if (cur_reg.prescale == {4'h0, sbg_pkg::SAMPLE_FIRST} ||
        cur_reg.prescale == {4'h0, sbg_pkg::SAMPLE_FIRST} + 6'h01 ||
        cur_reg.prescale == {4'h0, sbg_pkg::SAMPLE_FIRST} + 6'h02) begin
      cur_next.votes = {cur_reg.votes[1:0], cur_reg.rx_sync[1]};
    end
    if (cur_reg.prescale == {4'h0, sbg_pkg::SAMPLE_FIRST} + 6'h03) begin
      cur_next.rx_vote = (cur_reg.votes[0] & cur_reg.votes[1]) |
                         (cur_reg.votes[1] & cur_reg.votes[2]) |
                         (cur_reg.votes[0] & cur_reg.votes[2]);
    end

    // One eighth divider for the measuring counter
    if (measuring && clk_tick) begin
      cur_next.abd_div = cur_reg.abd_div + 3'h1;
    end

    // ****************************************
    // Rate measurement
    // ****************************************
    // Hazard: prescaler phase is kept at the first edge, so the count
    // Measurement sequence; may be off by one counter tick
    case (cur_reg.state)
      sbg_pkg::SBG_IDLE: begin
        if (cur_reg.rate_ctrl[sbg_pkg::RC_ABD_BIT] && abd_allowed) begin
          cur_next.state = sbg_pkg::SBG_START;
        end
      end
      sbg_pkg::SBG_START: begin
        cur_next.divisor = 16'h0000;
        cur_next.timer = 16'h0000;
        cur_next.edges = 3'h0;
        cur_next.abd_div = 3'h0;
        if (rx_fall) begin
          cur_next.state = sbg_pkg::SBG_FIRST;
        end
      end
      sbg_pkg::SBG_FIRST: begin
        if (rx_rise) begin
          cur_next.edges = 3'h1;
          cur_next.abd_div = 3'h0;
          cur_next.state = sbg_pkg::SBG_COUNT;
        end
      end
      sbg_pkg::SBG_COUNT: begin
        if (abd_tick) begin
          cur_next.divisor = cur_reg.divisor + 16'h0001;
          if (cur_reg.divisor == 16'hffff) begin
            cur_next.rate_ctrl[sbg_pkg::RC_OVF_BIT] = 1'b1;
          end
        end
        if (rx_rise) begin
          cur_next.edges = cur_reg.edges + 3'h1;
          if (cur_reg.edges + 3'h1 == sbg_pkg::ABD_EDGES) begin
            cur_next.rate_ctrl[sbg_pkg::RC_ABD_BIT] = 1'b0;
            cur_next.rx_flag = 1'b1;
            cur_next.state = sbg_pkg::SBG_IDLE;
          end
        end
      end
      default: begin
        cur_next.state = sbg_pkg::SBG_IDLE;
      end
    endcase

    // ****************************************
    // Wake handling
    // ****************************************
    // With wake enabled, hold measurement until the break has passed
    if (cur_reg.state == sbg_pkg::SBG_IDLE &&
        cur_reg.rate_ctrl[sbg_pkg::RC_ABD_BIT] &&
        cur_reg.rate_ctrl[sbg_pkg::RC_WAKE_BIT] && wake_break_seen_i) begin
      cur_next.rate_ctrl[sbg_pkg::RC_WAKE_BIT] = 1'b0;
    end

    // ****************************************
    // APB slave: one wait state, answer in access cycle after
    // ****************************************
    cur_next.pready = access;
    if (wr) begin
      case (paddr_i)
        sbg_pkg::ADDR_TX_CTRL: begin
          cur_next.tx_ctrl = (pwdata_i[7:0] & sbg_pkg::TX_CTRL_WMASK) |
                             (cur_reg.tx_ctrl & ~sbg_pkg::TX_CTRL_WMASK);
        end
        sbg_pkg::ADDR_RX_CTRL: begin
          cur_next.rx_ctrl = pwdata_i[7:0];
        end
        sbg_pkg::ADDR_RATE_CTRL: begin
          cur_next.rate_ctrl = pwdata_i[7:0] & sbg_pkg::RATE_CTRL_WMASK;
          // Hardware set of overflow wins over a software clear
          if (cur_next.rate_ctrl[sbg_pkg::RC_OVF_BIT] == 1'b0 &&
              cur_reg.state == sbg_pkg::SBG_COUNT && abd_tick &&
              cur_reg.divisor == 16'hffff) begin
            cur_next.rate_ctrl[sbg_pkg::RC_OVF_BIT] = 1'b1;
          end
          // Clearing enable by software aborts measurement
          if (!pwdata_i[sbg_pkg::RC_ABD_BIT]) begin
            cur_next.state = sbg_pkg::SBG_IDLE;
          end else if (!cur_reg.rate_ctrl[sbg_pkg::RC_ABD_BIT]) begin
            cur_next.state = sbg_pkg::SBG_IDLE; // restart sequence
          end
        end
        sbg_pkg::ADDR_DIV_HIGH: begin
          cur_next.divisor[15:8] = pwdata_i[7:0];
        end
        sbg_pkg::ADDR_DIV_LOW: begin
          cur_next.divisor[7:0] = pwdata_i[7:0];
        end
        default: begin
        end
      endcase
    end
    // Reading the buffer clears the flag; a new set in that cycle wins
    if (rd && paddr_i == sbg_pkg::ADDR_RX_BUF && !cur_next.rx_flag) begin
      cur_next.rx_flag = 1'b0;
    end else if (rd && paddr_i == sbg_pkg::ADDR_RX_BUF &&
                 !(cur_reg.state == sbg_pkg::SBG_COUNT && rx_rise &&
                   cur_reg.edges + 3'h1 == sbg_pkg::ABD_EDGES)) begin
      cur_next.rx_flag = 1'b0;
    end

    // Hold flag registered with the state so the output is a plain flop
    cur_next.hold = cur_next.state != sbg_pkg::SBG_IDLE;

    // ****************************************
    // Read data
    // ****************************************
    cur_next.prdata = 32'h0000_0000;
    if (rd) begin
      case (paddr_i)
        sbg_pkg::ADDR_TX_CTRL:   cur_next.prdata[7:0] = cur_reg.tx_ctrl;
        sbg_pkg::ADDR_RX_CTRL:   cur_next.prdata[7:0] = cur_reg.rx_ctrl;
        sbg_pkg::ADDR_RATE_CTRL: begin
          cur_next.prdata[7:0] = cur_reg.rate_ctrl;
          cur_next.prdata[sbg_pkg::RC_IDLE_BIT] = !measuring;
        end
        sbg_pkg::ADDR_DIV_HIGH:  cur_next.prdata[7:0] = cur_reg.divisor[15:8];
        sbg_pkg::ADDR_DIV_LOW:   cur_next.prdata[7:0] = cur_reg.divisor[7:0];
        sbg_pkg::ADDR_RX_BUF:    cur_next.prdata[7:0] = 8'h00;
        default:                 cur_next.prdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  // Synchroniser preloaded at line idle so no false edge follows reset
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cur_reg <= '{tx_ctrl: sbg_pkg::TX_CTRL_RESET,
                   rx_ctrl: sbg_pkg::RX_CTRL_RESET,
                   rate_ctrl: sbg_pkg::RATE_CTRL_RESET,
                   state: sbg_pkg::SBG_IDLE,
                   rx_sync: 2'h3,
                   rx_prev: 1'b1,
                   votes: 3'h7,
                   rx_vote: 1'b1,
                   default: '0};
    end else begin
      cur_reg <= cur_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Outputs straight from flops, pslverr_o tied low
  assign prdata_o       = cur_reg.prdata;
  assign pready_o       = cur_reg.pready;
  assign pslverr_o      = 1'b0;
  assign baud_tick_o    = cur_reg.baud_tick;
  assign sample_tick_o  = cur_reg.tick16;
  assign rx_level_o     = cur_reg.rx_vote;
  assign rx_hold_idle_o = cur_reg.hold;
  assign receive_flag_o = cur_reg.rx_flag;

endmodule

// ### verif/sbg_rate_gen_asserts.sv
// Concurrent checks on the ports of the serial rate generator
module sbg_rate_gen_asserts (
  input wire logic        clk_sys_i,
  input wire logic        reset_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        baud_tick_o,
  input wire logic        rx_hold_idle_o,
  input wire logic        receive_flag_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Bus and measurement properties
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  a_ready_one: assert property ($rose(penable_i) && psel_i |=> pready_o)
    else $error("no answer one cycle after access");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held past one cycle");
  a_ready_cause: assert property (pready_o |-> $past(psel_i && penable_i))
    else $error("ready without access");
  a_upper_zero: assert property (pready_o && !pwrite_i |->
    prdata_o[31:8] == 24'h0) else $error("upper read bits set");
  a_tick_gap: assert property (baud_tick_o |=> !baud_tick_o [*3])
    else $error("ticks closer than four clocks");
  a_flag_cause: assert property ($rose(receive_flag_o) |->
    $past(rx_hold_idle_o) || $past(rx_hold_idle_o, 2))
    else $error("flag raised outside measurement");
  a_flag_end: assert property ($fell(rx_hold_idle_o) |->
    ##[0:2] receive_flag_o) else $error("no flag at measurement end");
  // Flag clear loses to a set, so only reads outside measurement count
  a_flag_clear: assert property (psel_i && penable_i && !pready_o &&
    !pwrite_i && paddr_i == sbg_pkg::ADDR_RX_BUF && !rx_hold_idle_o
    |-> ##[1:2] !receive_flag_o) else $error("flag kept after read");
endmodule

// ### verif/sbg_rx_sender.sv
// Behavioural remote sender driving the receive line
module sbg_rx_sender (
  input  wire logic clk_i,
  output logic      rx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Line rests at the mark level between frames
  initial rx_o = 1'b1;
  // Start bit, eight data bits low first, stop bit; t clocks a bit
  task automatic send_byte(input logic [7:0] b, input int t);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      rx_o <= f[i];
      repeat (t - 1) @(posedge clk_i);
    end
  endtask
  // Low pulse: a glitch when short, a break when long
  task automatic pulse_low(input int t);
    @(posedge clk_i);
    rx_o <= 1'b0;
    repeat (t) @(posedge clk_i);
    rx_o <= 1'b1;
  endtask
endmodule

// ### verif/serial_baud_generator_autobaud_tb.sv
// Self-checking bench for the serial rate generator
module serial_baud_generator_autobaud_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i, reset_i, psel_i, penable_i, pwrite_i;
  logic wake_break_seen_i, pready_o, pslverr_o, rx_pin_i, lv;
  logic baud_tick_o, sample_tick_o, rx_level_o;
  logic rx_hold_idle_o, receive_flag_o;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  int fails, checks_done, n;
  // Modes: transmit control, rate control, tick period for divisor 0102h
  logic [7:0] tx_m [6] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h14, 8'h10};
  logic [7:0] rc_m [6] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h08};
  int per_m [6] = '{192, 48, 4144, 1036, 12, 1036};
  sbg_rate_gen u_dut (.clk_sys_i, .reset_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .rx_pin_i, .wake_break_seen_i, .baud_tick_o, .sample_tick_o,
    .rx_level_o, .rx_hold_idle_o, .receive_flag_o);
  sbg_rx_sender u_tx (.clk_i(clk_sys_i), .rx_o(rx_pin_i));
  // 20 MHz system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  // ****************************************
  // Access and compare tasks
  // ****************************************
  task automatic chk(input string s, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  // X-safe range compare, measured counts carry a phase error
  task automatic chk_rng(input string s, input logic [31:0] lo, hi, g);
    checks_done++;
    if ((^g === 1'bx) || g < lo || g > hi) begin
      fails++;
      $display("BAD %s exp %h..%h got %h", s, lo, hi, g);
    end
  endtask
  // One APB transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk_sys_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    rd = prdata_o;
    {psel_i, penable_i} <= 2'b00;
    chk("pready", 1, pready_o);
    chk("pslverr", 0, pslverr_o);
  endtask
  task automatic rd_chk(input string s, input logic [11:0] a,
                        input logic [31:0] m, e);
    apb(1'b0, a, 32'h0);
    chk(s, e, rd & m);
  endtask
  // Clocks up to and including the next tick
  task automatic tick_wait(output int c);
    c = 0;
    do begin
      @(posedge clk_sys_i);
      c++;
    end while (baud_tick_o !== 1'b1 && c < 9000);
  endtask
  // Calibration frame with a mid-frame look at the receiver hold
  task automatic meas(input int t, input logic h);
    fork
      u_tx.send_byte(8'h55, t);
      begin
        repeat (t * 5) @(posedge clk_sys_i);
        chk("hold", h, rx_hold_idle_o);
      end
    join
    repeat (20) @(posedge clk_sys_i);
  endtask
  task automatic end_sim();
    if (fails == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog, well above the expected run and under the cycle budget
  initial begin
    repeat (90000) @(posedge clk_sys_i);
    fails++;
    end_sim();
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    {reset_i, psel_i, penable_i, pwrite_i, wake_break_seen_i} = 5'h10;
    {paddr_i, pwdata_i, fails, checks_done} = '0;
    repeat (12) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rd_chk("tx_rst", sbg_pkg::ADDR_TX_CTRL, 'hff, sbg_pkg::TX_CTRL_RESET);
    rd_chk("rx_rst", sbg_pkg::ADDR_RX_CTRL, 'hff, 'h0);
    rd_chk("rate_rst", sbg_pkg::ADDR_RATE_CTRL, 'hbf, 'h0);
    rd_chk("unmapped", 12'h020, '1, 'h0);
    apb(1'b1, sbg_pkg::ADDR_TX_CTRL, 'hff);
    rd_chk("tx_rw", sbg_pkg::ADDR_TX_CTRL, '1, 'hff);
    apb(1'b1, sbg_pkg::ADDR_RX_CTRL, 'h5a);
    rd_chk("rx_rw", sbg_pkg::ADDR_RX_CTRL, '1, 'h5a);
    apb(1'b1, sbg_pkg::ADDR_RATE_CTRL, 'h88);
    rd_chk("ovf_set", sbg_pkg::ADDR_RATE_CTRL, 'hbf, 'h88);
    apb(1'b1, sbg_pkg::ADDR_RATE_CTRL, 'h0);
    rd_chk("ovf_clr", sbg_pkg::ADDR_RATE_CTRL, 'hbf, 'h0);
    apb(1'b1, sbg_pkg::ADDR_DIV_HIGH, 'h1);
    rd_chk("div_hi", sbg_pkg::ADDR_DIV_HIGH, '1, 'h1);
    // Divisor write restarts the timer, so the next period is whole
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, sbg_pkg::ADDR_TX_CTRL, {24'h0, tx_m[i]});
      apb(1'b1, sbg_pkg::ADDR_RATE_CTRL, {24'h0, rc_m[i]});
      apb(1'b1, sbg_pkg::ADDR_DIV_LOW, 'h2);
      tick_wait(n);
      tick_wait(n);
      chk("period", per_m[i], n);
      chk("sample", 1, sample_tick_o);
    end
    apb(1'b1, sbg_pkg::ADDR_TX_CTRL, 'h4);
    apb(1'b1, sbg_pkg::ADDR_RATE_CTRL, 'h0);
    tick_wait(n);
    repeat (20) @(posedge clk_sys_i);
    apb(1'b1, sbg_pkg::ADDR_DIV_LOW, 'h2);
    tick_wait(n);
    chk("restart", 1, n > 40);
    u_tx.pulse_low(1);
    lv = 1'b1;
    repeat (100) begin
      @(posedge clk_sys_i);
      lv = lv & rx_level_o;
    end
    chk("vote_glitch", 1, lv);
    fork
      u_tx.pulse_low(300);
      begin
        repeat (250) @(posedge clk_sys_i);
        chk("vote_low", 0, rx_level_o);
      end
    join
    // Counter ticks every 128 clocks here, eight 640-clock bits give 40
    apb(1'b1, sbg_pkg::ADDR_RATE_CTRL, 'h1);
    meas(640, 1'b1);
    rd_chk("abd_end", sbg_pkg::ADDR_RATE_CTRL, 'h1, 'h0);
    rd_chk("carry", sbg_pkg::ADDR_DIV_HIGH, '1, 'h0);
    apb(1'b0, sbg_pkg::ADDR_DIV_LOW, 'h0);
    chk_rng("count", 39, 41, rd);
    chk("flag_set", 1, receive_flag_o);
    apb(1'b0, sbg_pkg::ADDR_RX_BUF, 'h0);
    repeat (2) @(posedge clk_sys_i);
    chk("flag_clr", 0, receive_flag_o);
    // Break first; only the byte after it may be measured
    apb(1'b1, sbg_pkg::ADDR_RATE_CTRL, 'h3);
    u_tx.pulse_low(1500);
    @(posedge clk_sys_i);
    wake_break_seen_i <= 1'b1;
    @(posedge clk_sys_i);
    wake_break_seen_i <= 1'b0;
    meas(320, 1'b1);
    rd_chk("wake_end", sbg_pkg::ADDR_RATE_CTRL, 'h3, 'h0);
    apb(1'b0, sbg_pkg::ADDR_DIV_LOW, 'h0);
    chk_rng("count_wake", 19, 21, rd);
    apb(1'b0, sbg_pkg::ADDR_RX_BUF, 'h0);
    apb(1'b1, sbg_pkg::ADDR_TX_CTRL, 'h14);
    apb(1'b1, sbg_pkg::ADDR_RATE_CTRL, 'h1);
    meas(640, 1'b0);
    chk("sync_flag", 0, receive_flag_o);
    apb(1'b1, sbg_pkg::ADDR_RATE_CTRL, 'h0);
    end_sim();
  end
endmodule
bind sbg_rate_gen sbg_rate_gen_asserts u_chk (.clk_sys_i, .reset_i,
  .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o,
  .baud_tick_o, .rx_hold_idle_o, .receive_flag_o);
